// [verilog/burst4_byte_write_sram_cycle.sv]
// Burst-of-four read and write sequencers with byte-lane write masking
`timescale 1ns/1ns
`default_nettype none
module burst4_byte_write_sram_cycle
    import sram_burst_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rstn,
    input  wire logic [1:0]        org_mode,
    output logic                   k_edge,
    input  wire logic              read_req_n,
    input  wire logic              write_req_n,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              lane0_write_select_n,
    input  wire logic              lane1_write_select_n,
    input  wire logic              lane2_write_select_n,
    input  wire logic              lane3_write_select_n,
    output logic                   write_ready,
    output logic [DATA_W-1:0]      rdata,
    output logic                   rdata_valid,
    output logic                   rdata_oe_n
);
    // Clock phase: high-low pairs of ref_clk stand for the true/complement edges
    logic                ph_q, ph_d;
    seq_e                st_q [2];
    seq_e                st_d [2];
    logic [ADDR_W-1:0]   cur_q [2];
    logic [ADDR_W-1:0]   cur_d [2];
    logic [ADDR_W-1:0]   nxt_q [2];
    logic [ADDR_W-1:0]   nxt_d [2];
    logic [1:0]          pend_q, pend_d;
    logic [1:0]          prev_q, prev_d;
    logic [1:0]          raw, req, take;
    logic                push;
    logic [1:0]          push_beat;
    logic [IADDR_W-1:0]  push_idx;
    logic [LANES-1:0]    sel_n, push_mask;
    logic                fifo_in_ready, fifo_out_valid, drain;
    logic [ENTRY_W-1:0]  fifo_out;
    logic [3:0]          level;
    logic [3:0]          inflight_q, inflight_d;
    logic                fetch;
    logic [1:0]          f_beat;
    logic [IADDR_W-1:0]  d_idx;
    logic [DATA_W-1:0]   d_data, old_word, merged;
    logic [LANES-1:0]    d_mask;
    logic [DATA_W-1:0]   rdata_q, rdata_d;
    logic                valid_q, valid_d;
    logic [DATA_W-1:0]   mem_q [MEM_WORDS];

    assign k_edge = ~ph_q;
    assign sel_n  = {lane3_write_select_n, lane2_write_select_n,
                     lane1_write_select_n, lane0_write_select_n};

    // Request decode; a read beats a write on the same edge
    assign raw[RD]  = ~read_req_n;
    assign raw[WR]  = ~write_req_n;
    assign req[RD]  = raw[RD];
    assign req[WR]  = raw[WR] & read_req_n;
    assign take[RD] = k_edge & req[RD] & ~prev_q[RD];
    assign take[WR] = k_edge & req[WR] & ~prev_q[WR] & write_ready;

    // Both sequencers step through the same states, only on true edges
    always_comb begin
        ph_d   = ~ph_q;
        pend_d = pend_q;
        prev_d = prev_q;
        for (int i = 0; i < 2; i++) begin
            st_d[i]  = st_q[i];
            cur_d[i] = cur_q[i];
            nxt_d[i] = nxt_q[i];
            if (k_edge) begin
                prev_d[i] = raw[i];
                case (st_q[i])
                    SEQ_IDLE: begin
                        if (take[i]) begin
                            st_d[i]  = SEQ_ADDR;
                            cur_d[i] = addr;
                        end
                    end
                    SEQ_ADDR: begin
                        st_d[i] = SEQ_FIRST;
                    end
                    SEQ_FIRST: begin
                        st_d[i] = SEQ_LAST;
                        if (take[i]) begin
                            pend_d[i] = 1'b1;
                            nxt_d[i]  = addr;
                        end
                    end
                    SEQ_LAST: begin
                        // The burst ends here by itself after four beats
                        if (pend_q[i]) begin
                            st_d[i]   = SEQ_FIRST;
                            cur_d[i]  = nxt_q[i];
                            pend_d[i] = 1'b0;
                        end else if (take[i]) begin
                            st_d[i]  = SEQ_ADDR;
                            cur_d[i] = addr;
                        end else begin
                            st_d[i] = SEQ_IDLE;
                        end
                    end
                    default: begin
                        st_d[i] = SEQ_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ph_q   <= PH_RST;
            pend_q <= '0;
            prev_q <= '0;
            for (int i = 0; i < 2; i++) begin
                st_q[i]  <= SEQ_IDLE;
                cur_q[i] <= '0;
                nxt_q[i] <= '0;
            end
        end else begin
            ph_q   <= ph_d;
            pend_q <= pend_d;
            prev_q <= prev_d;
            for (int i = 0; i < 2; i++) begin
                st_q[i]  <= st_d[i];
                cur_q[i] <= cur_d[i];
                nxt_q[i] <= nxt_d[i];
            end
        end
    end

    // Write beats land on both phases; selects are looked at only here
    always_comb begin
        push      = 1'b0;
        push_beat = 2'h0;
        push_idx  = {cur_q[WR], 2'h0};
        case (st_q[WR])
            SEQ_ADDR: begin
                push      = ~ph_q;
                push_beat = 2'h0;
            end
            SEQ_FIRST: begin
                push      = 1'b1;
                push_beat = ph_q ? 2'h1 : 2'h2;
            end
            SEQ_LAST: begin
                push      = ph_q | pend_q[WR];
                push_beat = ph_q ? 2'h3 : 2'h0;
            end
            default: begin
                push = 1'b0;
            end
        endcase
        if (st_q[WR] == SEQ_LAST && !ph_q) begin
            push_idx = {nxt_q[WR], push_beat};
        end else begin
            push_idx = {cur_q[WR], push_beat};
        end
    end

    // Absent lanes of narrow organisations are always masked
    for (genvar l = 0; l < LANES; l++) begin : g_mask
        assign push_mask[l] = sel_n[l] | ~lane_on(org_mode, l);
    end

    // Room is reserved at acceptance, so a started burst never stalls
    always_comb begin
        inflight_d = inflight_q + (take[WR] ? 4'(BURST_LEN) : 4'h0) - 4'(push);
    end
    assign write_ready = (5'(level) + 5'(inflight_q)) <= 5'(FIFO_DEPTH - BURST_LEN);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            inflight_q <= '0;
        end else begin
            inflight_q <= inflight_d;
        end
    end

    // Each beat's mask rides with its data through the buffer
    beat_fifo #(
        .WIDTH (ENTRY_W),
        .DEPTH (FIFO_DEPTH)
    ) i_beat_fifo (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   ({push_idx, wdata, push_mask}),
        .out_valid (fifo_out_valid),
        .out_ready (drain),
        .out_data  (fifo_out),
        .level     (level)
    );

    // Read fetches one cycle ahead of each output beat
    always_comb begin
        fetch  = 1'b0;
        f_beat = 2'h0;
        case (st_q[RD])
            SEQ_FIRST: begin
                fetch  = 1'b1;
                f_beat = ph_q ? 2'h0 : 2'h1;
            end
            SEQ_LAST: begin
                fetch  = 1'b1;
                f_beat = ph_q ? 2'h2 : 2'h3;
            end
            default: begin
                fetch = 1'b0;
            end
        endcase
    end

    // The array has one port; reads win and the buffer absorbs the stall
    assign drain = fifo_out_valid & ~fetch;
    assign {d_idx, d_data, d_mask} = fifo_out;
    assign old_word = mem_q[d_idx];

    for (genvar l = 0; l < LANES; l++) begin : g_merge
        assign merged[l*LANE_W +: LANE_W] = d_mask[l] ?
            old_word[l*LANE_W +: LANE_W] : d_data[l*LANE_W +: LANE_W];
    end

    always_ff @(posedge ref_clk) begin
        if (drain) begin
            mem_q[d_idx] <= merged;
        end
    end

    // Output beats; a read does not see writes still waiting in the buffer
    always_comb begin
        rdata_d = fetch ? mem_q[{cur_q[RD], f_beat}] : rdata_q;
        valid_d = fetch;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= '0;
            valid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            valid_q <= valid_d;
        end
    end

    assign rdata       = rdata_q;
    assign rdata_valid = valid_q;
    assign rdata_oe_n  = ~valid_q;

    // Checks
    logic [LANE_W-1:0] old_l0, new_l0;
    assign old_l0 = old_word[LANE_W-1:0];
    assign new_l0 = d_data[LANE_W-1:0];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    sequence s_wr_beats;
        (push && push_beat == 2'h0) ##1 (push && push_beat == 2'h1)
        ##1 (push && push_beat == 2'h2) ##1 (push && push_beat == 2'h3);
    endsequence
    sequence s_fetch_order;
        (fetch && f_beat == 2'h0) ##1 (fetch && f_beat == 2'h1)
        ##1 (fetch && f_beat == 2'h2) ##1 (fetch && f_beat == 2'h3);
    endsequence

    property p_wr_burst;
        take[WR] |-> ##2 s_wr_beats;
    endproperty
    a_wr_burst: assert property (p_wr_burst) else $error("write burst beats wrong");

    property p_rd_burst;
        take[RD] |-> ##4 rdata_valid [*4];
    endproperty
    a_rd_burst: assert property (p_rd_burst) else $error("read burst beats wrong");

    property p_fetch_order;
        take[RD] |-> ##3 s_fetch_order;
    endproperty
    a_fetch_order: assert property (p_fetch_order) else $error("read order wrong");

    property p_rd_prec;
        (k_edge && !read_req_n && !write_req_n && !prev_q[RD] && st_q[WR] == SEQ_IDLE)
        |=> st_q[WR] == SEQ_IDLE && st_q[RD] != SEQ_IDLE;
    endproperty
    a_rd_prec: assert property (p_rd_prec) else $error("write not dropped");

    property p_k_only;
        (st_q[WR] != $past(st_q[WR])) || (st_q[RD] != $past(st_q[RD])) |-> $past(k_edge);
    endproperty
    a_k_only: assert property (p_k_only) else $error("state moved off true edge");

    property p_no_b2b;
        take[RD] |-> ##2 !take[RD];
    endproperty
    a_no_b2b: assert property (p_no_b2b) else $error("consecutive read taken");

    property p_concurrent;
        (k_edge && req[WR] && !prev_q[WR] && write_ready && st_q[RD] != SEQ_IDLE)
        |=> st_q[WR] == SEQ_ADDR || pend_q[WR];
    endproperty
    a_concurrent: assert property (p_concurrent) else $error("write blocked");

    property p_mask_keep;
        (drain && d_mask[0]) |=> mem_q[$past(d_idx)][LANE_W-1:0] == $past(old_l0);
    endproperty
    a_mask_keep: assert property (p_mask_keep) else $error("masked lane changed");

    property p_lane_write;
        (drain && !d_mask[0]) |=> mem_q[$past(d_idx)][LANE_W-1:0] == $past(new_l0);
    endproperty
    a_lane_write: assert property (p_lane_write) else $error("lane not written");

    property p_x18_lanes;
        (push && org_mode == ORG_X18) |-> push_mask[3:2] == 2'h3 && push_mask[1:0] == sel_n[1:0];
    endproperty
    a_x18_lanes: assert property (p_x18_lanes) else $error("x18 mask wrong");

    property p_x36_lanes;
        (push && org_mode == ORG_X36) |-> push_mask == sel_n;
    endproperty
    a_x36_lanes: assert property (p_x36_lanes) else $error("x36 mask wrong");

    property p_room;
        push |-> fifo_in_ready;
    endproperty
    a_room: assert property (p_room) else $error("beat pushed into full buffer");

endmodule
`default_nettype wire

// [verilog/sram_burst_pkg.sv]
// Constants, types and helpers for the burst-of-four SRAM cycle controller
// What this block does
// - x9: low lane0 select at a data edge writes that lane; high keeps it.
// - x18: two active-low selects gate lanes 0 and 1 independently per beat.
// - x36: four active-low selects gate one lane each in ascending order.
// - Selects are used only in beats of an accepted write burst.
// - Captured address is extended with two internal low bits for the beats.
// - Burst order is always base+0, +1, +2, +3 with no wrap options.
// - Every read or write burst ends by itself after exactly four beats.
// - Read and write sequencers run independently and may overlap.
// - Read and write requested together: read starts, write is dropped.
// - Sequencer states change only on true clock edges.
// - Write beats are taken, and read beats given, on both clock phases.
// - Write needs read high, write low; read needs read low; both high is idle.
// - Same request on consecutive true edges: the second one is ignored.
package sram_burst_pkg;

    localparam int ADDR_W     = 6;
    localparam int IADDR_W    = ADDR_W + 2;
    localparam int LANE_W     = 9;
    localparam int LANES      = 4;
    localparam int DATA_W     = LANE_W * LANES;
    localparam int BURST_LEN  = 4;
    localparam int FIFO_DEPTH = 8;
    localparam int ENTRY_W    = IADDR_W + DATA_W + LANES;
    localparam int MEM_WORDS  = 1 << IADDR_W;
    localparam int CNT_W      = 5;

    // Cycles from an accepted request to its first beat at the ports
    localparam int WR_LAT_CYC = 2;
    localparam int RD_LAT_CYC = 4;

    // Reset values
    localparam logic PH_RST = 1'b0;

    // Sequencer index
    localparam int RD = 0;
    localparam int WR = 1;

    // Data organisation
    localparam logic [1:0] ORG_X9  = 2'h0;
    localparam logic [1:0] ORG_X18 = 2'h1;
    localparam logic [1:0] ORG_X36 = 2'h2;

    // One state spans a true-clock period, from the complement edge onward
    typedef enum logic [1:0] {
        SEQ_IDLE  = 2'h0,
        SEQ_ADDR  = 2'h1,
        SEQ_FIRST = 2'h2,
        SEQ_LAST  = 2'h3
    } seq_e;

    // Lane present in the selected organisation
    function automatic logic lane_on(input logic [1:0] org, input int lane);
        case (org)
            ORG_X9:  lane_on = (lane == 0);
            ORG_X18: lane_on = (lane < 2);
            default: lane_on = 1'b1;
        endcase
    endfunction

endpackage

// [verilog/beat_fifo.sv]
// Synchronous FIFO holding write beats between the port and the array
`timescale 1ns/1ns
`default_nettype none
module beat_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic                       ref_clk,
    input  wire logic                       rstn,
    input  wire logic                       in_valid,
    output logic                            in_ready,
    input  wire logic [WIDTH-1:0]           in_data,
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [WIDTH-1:0]                out_data,
    output logic [$clog2(DEPTH+1)-1:0]      level
);
    localparam int PW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH+1);

    logic [WIDTH-1:0] buf_q [DEPTH];
    logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [LW-1:0]    cnt_q, cnt_d;
    logic             do_in, do_out;

    // Honest flags straight from the count
    assign in_ready  = (cnt_q != LW'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = buf_q[rd_q];
    assign level     = cnt_q;
    assign do_in     = in_valid & in_ready;
    assign do_out    = out_valid & out_ready;

    // Pointer and count update
    always_comb begin
        wr_d  = do_in ? ((wr_q == PW'(DEPTH-1)) ? '0 : wr_q + PW'(1)) : wr_q;
        rd_d  = do_out ? ((rd_q == PW'(DEPTH-1)) ? '0 : rd_q + PW'(1)) : rd_q;
        cnt_d = cnt_q + LW'(do_in) - LW'(do_out);
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // Storage needs no reset; empty slots are never read out
    always_ff @(posedge ref_clk) begin
        if (do_in) begin
            buf_q[wr_q] <= in_data;
        end
    end

endmodule
`default_nettype wire

// [tb/host_ctl.sv]
// Behavioural memory controller driving requests, address and beats
`timescale 1ns/1ns
`default_nettype none
module host_ctl
    import sram_burst_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire logic         k_edge,
    input  wire logic         write_ready,
    output logic              read_req_n,
    output logic              write_req_n,
    output logic [ADDR_W-1:0] addr,
    output logic [DATA_W-1:0] wdata,
    output logic              lane0_write_select_n,
    output logic              lane1_write_select_n,
    output logic              lane2_write_select_n,
    output logic              lane3_write_select_n
);
    int cyc;
    int last_req [2];

    // Idle bus at time zero
    initial begin
        cyc = 0;
        last_req = '{-8, -8};
        put(1'b0, 1'b0, '0, '0, 4'hf);
    end

    // Cycle count for request spacing
    always @(posedge ref_clk) cyc <= cyc + 1;

    // Wait for a true edge; same-kind requests stay at least four cycles (two true edges) apart
    task automatic align(input int kind);
        do @(negedge ref_clk);
        while (k_edge !== 1'b1 || cyc - last_req[kind] < 4
               || (kind == WR && write_ready !== 1'b1));
    endtask

    // One cycle of bus values; released lines show the inverse of their last value
    task automatic put(input logic rd, input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, input logic [3:0] sel_n);
        read_req_n = ~rd;
        write_req_n = ~wr;
        if (rd)
            last_req[RD] = cyc;
        if (wr)
            last_req[WR] = cyc;
        addr = (rd || wr) ? a : ~addr;
        wdata = (sel_n == 4'hf) ? ~wdata : d;
        {lane3_write_select_n, lane2_write_select_n, lane1_write_select_n,
         lane0_write_select_n} = sel_n;
    endtask
endmodule
`default_nettype wire

// [tb/test_burst4_byte_write_sram_cycle.sv]
// Self-checking bench for the burst-of-four SRAM cycle controller
`timescale 1ns/1ns
`default_nettype none
module test_burst4_byte_write_sram_cycle
    import sram_burst_pkg::*;
;
    typedef struct packed {
        logic [1:0]        org;
        logic [ADDR_W-1:0] a;
        logic [15:0]       sel;
        logic [15:0]       chg;
    } row_s;

    // Per-beat selects (beat 3 in the top nibble) beside the lanes that must change
    localparam row_s ROWS [6] = '{
        '{ORG_X36, 6'h01, 16'h0000, 16'hffff},
        '{ORG_X36, 6'h02, 16'h7bde, 16'h8421},
        '{ORG_X36, 6'h03, 16'hffff, 16'h0000},
        '{ORG_X18, 6'h04, 16'hfde0, 16'h0213},
        '{ORG_X9,  6'h05, 16'hfe01, 16'h0110},
        '{2'h3,    6'h06, 16'h0000, 16'hffff}
    };

    logic              ref_clk;
    logic              rstn;
    logic [1:0]        org_mode;
    logic              k_edge;
    logic              k_was;
    logic              read_req_n;
    logic              write_req_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        sel_n;
    logic              write_ready;
    logic [DATA_W-1:0] rdata;
    logic              rdata_valid;
    logic              rdata_oe_n;
    logic [DATA_W-1:0] shadow [MEM_WORDS];
    int                n_fail = 0;
    int                comparisons = 0;
    int                cyc = 0;

    burst4_byte_write_sram_cycle i_burst4_byte_write_sram_cycle (
        .ref_clk(ref_clk), .rstn(rstn), .org_mode(org_mode), .k_edge(k_edge),
        .read_req_n(read_req_n), .write_req_n(write_req_n), .addr(addr), .wdata(wdata),
        .lane0_write_select_n(sel_n[0]), .lane1_write_select_n(sel_n[1]),
        .lane2_write_select_n(sel_n[2]), .lane3_write_select_n(sel_n[3]),
        .write_ready(write_ready), .rdata(rdata), .rdata_valid(rdata_valid),
        .rdata_oe_n(rdata_oe_n)
    );

    host_ctl i_host_ctl (
        .ref_clk(ref_clk), .k_edge(k_edge), .write_ready(write_ready),
        .read_req_n(read_req_n), .write_req_n(write_req_n), .addr(addr), .wdata(wdata),
        .lane0_write_select_n(sel_n[0]), .lane1_write_select_n(sel_n[1]),
        .lane2_write_select_n(sel_n[2]), .lane3_write_select_n(sel_n[3])
    );

    // Beat data with every 9-bit lane distinct
    function automatic logic [DATA_W-1:0] pat(input logic [7:0] s);
        pat = {s, ~s, s ^ 8'h5a, 1'b1, s + 8'h33, 3'h5};
    endfunction

    task automatic check_bit(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask

    task automatic check_word(input string what, input logic [DATA_W-1:0] exp,
                              input logic [DATA_W-1:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        if (n_fail == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // One request, beats two to five cycles later, read beats checked four to seven later
    task automatic burst(input logic rd, input logic wr, input logic [ADDR_W-1:0] a,
                         input logic [2:0] salt, input logic [15:0] sel,
                         input logic [15:0] chg, input bit dbl);
        logic [DATA_W-1:0] d [4];
        logic [DATA_W-1:0] e [4];
        for (int b = 0; b < 4; b++) begin
            d[b] = pat({salt, a[2:0], 2'(b)});
            e[b] = shadow[{a, 2'(b)}];
        end
        i_host_ctl.align((wr && !rd) ? WR : RD);
        i_host_ctl.put(rd, wr, a, '0, 4'hf);
        for (int t = 1; t <= 8; t++) begin
            @(negedge ref_clk);
            if (dbl && t == 2)
                i_host_ctl.put(1'b1, 1'b0, a + 6'h01, '0, 4'hf);
            else if (t >= 2 && t <= 5)
                i_host_ctl.put(1'b0, 1'b0, a, d[t-2], sel[4*(t-2) +: 4]);
            else
                i_host_ctl.put(1'b0, 1'b0, a, '0, 4'hf);
            if (rd && t >= 3) begin
                check_bit("rdata_valid", t >= 4 && t <= 7, rdata_valid);
                check_bit("rdata_oe_n", !(t >= 4 && t <= 7), rdata_oe_n);
                if (t >= 4 && t <= 7)
                    check_word("rdata", e[t-4], rdata);
            end
        end
        // A read beside a write wins, so only a lone write changes the array
        if (wr && !rd)
            for (int b = 0; b < 4; b++)
                for (int l = 0; l < LANES; l++)
                    if (chg[4*b+l])
                        shadow[{a, 2'(b)}][9*l +: 9] = d[b][9*l +: 9];
    endtask

    // Reads every second true edge hold the array port while writes fill the buffer
    task automatic stream(input int n);
        logic [7:0] took;
        logic       refused;
        logic       rd;
        logic       wr;
        logic       on;
        refused = 1'b0;
        i_host_ctl.align(RD);
        for (int t = 0; t < 4 * n + 8; t++) begin
            if (t > 0)
                @(negedge ref_clk);
            rd = (t % 4 == 0) && (t < 4 * n);
            wr = (t % 4 == 2) && (t < 4 * n);
            on = (t >= 4) && (t < 4 * n + 4);
            if (wr)
                took[t/4] = write_ready;
            if (write_ready === 1'b0)
                refused = 1'b1;
            i_host_ctl.put(rd, wr, rd ? 6'h01 : 6'(8 + t / 4),
                           pat({3'h6, 3'(t / 4 - 1), 2'(t % 4)}), on ? 4'h0 : 4'hf);
            check_bit("rdata_valid", on, rdata_valid);
            if (on)
                check_word("rdata", shadow[{6'h01, 2'(t % 4)}], rdata);
        end
        check_bit("first write taken", 1'b1, took[0]);
        check_bit("buffer refusal", 1'b1, refused);
        for (int k = 0; k < n; k++)
            if (took[k] === 1'b1)
                for (int b = 0; b < 4; b++)
                    shadow[{6'(8 + k), 2'(b)}] = pat({3'h6, 3'(k), 2'(b)});
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_fail++;
            give_verdict();
        end
    end

    initial begin
        rstn = 1'b0;
        org_mode = ORG_X36;
        repeat (16) @(negedge ref_clk);
        check_bit("rdata_valid", 1'b0, rdata_valid);
        check_bit("rdata_oe_n", 1'b1, rdata_oe_n);
        check_bit("write_ready", 1'b1, write_ready);
        check_bit("k_edge", 1'b1, k_edge);
        check_word("rdata", '0, rdata);
        rstn = 1'b1;
        @(negedge ref_clk);
        k_was = k_edge;
        @(negedge ref_clk);
        check_bit("k_edge toggle", 1'b1, k_edge ^ k_was);
        // Preload, masked overwrite, read back with all lanes visible
        foreach (ROWS[i]) begin
            burst(1'b0, 1'b1, ROWS[i].a, 3'h0, 16'h0000, 16'hffff, 1'b0);
            org_mode = ROWS[i].org;
            burst(1'b0, 1'b1, ROWS[i].a, 3'h1, ROWS[i].sel, ROWS[i].chg, 1'b0);
            repeat (16) @(negedge ref_clk);
            org_mode = ORG_X36;
            burst(1'b1, 1'b0, ROWS[i].a, 3'h0, 16'hffff, 16'h0000, 1'b0);
        end
        // Both requests at once, then a read on the very next true edge
        burst(1'b1, 1'b1, 6'h01, 3'h7, 16'h0000, 16'h0000, 1'b0);
        burst(1'b1, 1'b0, 6'h02, 3'h0, 16'hffff, 16'h0000, 1'b1);
        repeat (16) @(negedge ref_clk);
        burst(1'b1, 1'b0, 6'h01, 3'h0, 16'hffff, 16'h0000, 1'b0);
        for (int k = 0; k < 6; k++)
            burst(1'b0, 1'b1, 6'(8 + k), 3'h5, 16'h0000, 16'hffff, 1'b0);
        repeat (16) @(negedge ref_clk);
        stream(6);
        repeat (40) @(negedge ref_clk);
        check_bit("write_ready", 1'b1, write_ready);
        for (int k = 0; k < 6; k++)
            burst(1'b1, 1'b0, 6'(8 + k), 3'h0, 16'hffff, 16'h0000, 1'b0);
        // Reset in mid-burst silences the read port at once; the array survives
        i_host_ctl.align(RD);
        i_host_ctl.put(1'b1, 1'b0, 6'h01, '0, 4'hf);
        @(negedge ref_clk);
        i_host_ctl.put(1'b0, 1'b0, 6'h01, '0, 4'hf);
        repeat (4) @(negedge ref_clk);
        rstn = 1'b0;
        #1;
        check_bit("rdata_valid", 1'b0, rdata_valid);
        check_bit("rdata_oe_n", 1'b1, rdata_oe_n);
        repeat (2) @(negedge ref_clk);
        rstn = 1'b1;
        burst(1'b1, 1'b0, 6'h01, 3'h0, 16'hffff, 16'h0000, 1'b0);
        give_verdict();
    end
endmodule
`default_nettype wire
